// ---- rtl/nand_host_pkg.sv ----
package nand_host_pkg;
   // =========================================================
   // Flash command codes
   localparam logic [7:0] cmd_read_setup = 8'h00;
   localparam logic [7:0] cmd_read_confirm = 8'h30;
   localparam logic [7:0] cmd_random_out = 8'h05;
   localparam logic [7:0] cmd_random_out_confirm = 8'he0;
   localparam logic [7:0] cmd_cache_read = 8'h31;
   localparam logic [7:0] cmd_cache_read_end = 8'h34;
   localparam logic [7:0] cmd_program_load = 8'h80;
   localparam logic [7:0] cmd_random_in = 8'h85;
   localparam logic [7:0] cmd_program_confirm = 8'h10;
   localparam logic [7:0] cmd_cache_program = 8'h15;
   localparam logic [7:0] cmd_erase_setup = 8'h60;
   localparam logic [7:0] cmd_erase_confirm = 8'hd0;
   localparam logic [7:0] cmd_read_id = 8'h90;
   localparam logic [7:0] cmd_read_status = 8'h70;
   localparam logic [7:0] cmd_reset = 8'hff;
   localparam logic [7:0] id_address = 8'h00;
   // =========================================================
   // Register map of the controller, byte addresses
   localparam logic [7:0] reg_control = 8'h00;
   localparam logic [7:0] reg_status = 8'h04;
   localparam logic [7:0] reg_wdata = 8'h08;
   localparam logic [7:0] reg_rdata = 8'h0c;
   localparam logic [7:0] reg_partial = 8'h10;
   // Control word fields: [7:0] byte, [9:8] kind, [10] chip select, [11] protect_n.
   localparam int ctl_kind_lsb = 8;
   localparam int ctl_cs_bit = 10;
   localparam int ctl_wp_bit = 11;
   localparam logic [1:0] kind_command = 2'h0;
   localparam logic [1:0] kind_address = 2'h1;
   localparam logic [1:0] kind_data_in = 2'h2;
   localparam logic [1:0] kind_data_out = 2'h3;
   // Status word fields.
   localparam int st_busy_bit = 0;
   localparam int st_ready_bit = 1;
   localparam int st_refused_bit = 2;
   localparam logic [2:0] partial_limit = 3'h4;
   // =========================================================
   // Pin timing, 200 MHz clock
   localparam int clock_mhz = 200;
   localparam int strobe_low_ns = 15;
   localparam int strobe_high_ns = 15;
   localparam int read_access_delay_ns = 20;
   localparam int strobe_low_cycles = (strobe_low_ns * clock_mhz + 999) / 1000;
   localparam int strobe_high_cycles = (strobe_high_ns * clock_mhz + 999) / 1000;
   localparam int access_cycles = (read_access_delay_ns * clock_mhz + 999) / 1000;
   localparam int hold_low_cycles =
      (access_cycles > strobe_low_cycles) ? access_cycles : strobe_low_cycles;
   localparam logic [3:0] low_count = 4'(hold_low_cycles);
   localparam logic [3:0] high_count = 4'(strobe_high_cycles);
endpackage

// ---- rtl/nand_host.sv ----
// =========================================================
`timescale 1ns/100ps
`default_nettype none
module nand_host
   import nand_host_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Flash pins
   output logic chip_select_n,
   output logic command_latch_sel,
   output logic address_latch_sel,
   output logic input_strobe_n,
   output logic output_strobe_n,
   output logic protect_n,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe,
   input wire logic [7:0] data_bus_in,
   input wire logic ready_busy_n
);
   // =========================================================
   // Pin cycle sequencer
   typedef enum logic [2:0]
   {
      st_idle = 3'b001,
      st_low = 3'b010,
      st_high = 3'b100
   } cycle_e;
   cycle_e state;
   cycle_e next_state;
   logic [3:0] count;
   logic [1:0] kind;
   logic [7:0] out_byte;
   logic [7:0] read_byte;
   logic refused;
   logic [2:0] partial_count;
   logic in_program;
   // Bus address phase capture.
   logic wr_pend;
   logic [7:0] wr_addr;
   logic accept;
   logic start;
   logic is_cmd;
   assign accept = hsel & hready & htrans[1];
   assign hresp = 1'b0;
   // The data phase of a control write stalls while a pin cycle runs.
   assign hreadyout = !(wr_pend && wr_addr == reg_control && state != st_idle);
   assign start = wr_pend && wr_addr == reg_control && state == st_idle;
   assign is_cmd = hwdata[ctl_kind_lsb +: 2] == kind_command;

   // Address phase register.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else if (hreadyout)
      begin
         wr_pend <= accept & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // Read data, registered on the address phase.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         hrdata <= 32'h0;
      else if (accept && !hwrite && hreadyout)
         case (haddr[7:0])
            reg_status: hrdata <= {29'h0, refused, ready_busy_n, state != st_idle};
            reg_rdata: hrdata <= {24'h0, read_byte};
            reg_partial: hrdata <= {29'h0, partial_count};
            reg_control: hrdata <= {20'h0, protect_n, !chip_select_n, kind, out_byte};
            default: hrdata <= 32'h0;
         endcase
   end

   // Next state of the strobe sequencer.
   always_comb
   begin
      next_state = state;
      case (state)
         st_idle: if (start && !refused_now()) next_state = st_low;
         st_low: if (count == 4'h0) next_state = st_high;
         st_high: if (count == 4'h0) next_state = st_idle;
         default: next_state = st_idle;
      endcase
   end

   // Partial program limit: a fifth load of one page is refused.
   function automatic logic refused_now();
      refused_now = is_cmd && hwdata[7:0] == cmd_program_load
         && partial_count == partial_limit;
   endfunction

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= st_idle;
         count <= 4'h0;
      end
      else
      begin
         state <= next_state;
         if (state == st_idle)
            count <= low_count - 4'h1;
         else if (state == st_low && count == 4'h0)
            count <= high_count - 4'h1;
         else if (count != 4'h0)
            count <= count - 4'h1;
      end
   end

   // Latched control word of the cycle in flight.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         kind <= kind_command;
         out_byte <= 8'h00;
         chip_select_n <= 1'b1;
         protect_n <= 1'b0;
         refused <= 1'b0;
      end
      else if (start)
      begin
         kind <= hwdata[ctl_kind_lsb +: 2];
         out_byte <= hwdata[7:0];
         chip_select_n <= !hwdata[ctl_cs_bit];
         protect_n <= hwdata[ctl_wp_bit];
         refused <= refused_now();
      end
   end

   // Count program loads of the page; only reset or erase setup clears the tally.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         partial_count <= 3'h0;
         in_program <= 1'b0;
      end
      else if (start && is_cmd && !refused_now())
      begin
         if (hwdata[7:0] == cmd_program_load)
         begin
            partial_count <= partial_count + 3'h1;
            in_program <= 1'b1;
         end
         else if (hwdata[7:0] == cmd_reset || hwdata[7:0] == cmd_erase_setup)
         begin
            partial_count <= 3'h0;
            in_program <= 1'b0;
         end
      end
   end

   // Pin drive. Latch selects stay up through the whole cycle for setup/hold.
   always_comb
   begin
      command_latch_sel = state != st_idle && kind == kind_command;
      address_latch_sel = state != st_idle && kind == kind_address;
      input_strobe_n = !(state == st_low && kind != kind_data_out);
      output_strobe_n = !(state == st_low && kind == kind_data_out);
      data_bus_oe = state != st_idle && kind != kind_data_out;
      data_bus_out = out_byte;
   end

   // Data is sampled at the end of the low phase, past the access delay.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         read_byte <= 8'h00;
      else if (state == st_low && count == 4'h0 && kind == kind_data_out)
         read_byte <= data_bus_in;
   end

   // =========================================================
   // Command tracker
   // The pin sequencer decodes the byte only to tally program loads and refuse an over-limit one, so software builds every flash sequence
   // itself. This tracker only remembers where that sequence stands, which
   // lets the checks below watch the host side of each operation.
   logic [7:0] last_cmd;
   logic in_cache_read;
   logic cmd_taken;
   assign cmd_taken = start && is_cmd && !refused_now();

   // Last command byte sent; power-up counts as read setup.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         last_cmd <= cmd_read_setup;
      else if (cmd_taken)
         last_cmd <= hwdata[7:0];
   end

   // Cache read runs from 31h until 34h or reset; status reads do not end it.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         in_cache_read <= 1'b0;
      else if (cmd_taken && hwdata[7:0] == cmd_cache_read)
         in_cache_read <= 1'b1;
      else if (cmd_taken && (hwdata[7:0] == cmd_cache_read_end || hwdata[7:0] == cmd_reset))
         in_cache_read <= 1'b0;
   end

   // =========================================================
   // Checks
   // The write strobe stays low for the whole low phase, then rises.
   property p_strobe_low;
      @(posedge clock) disable iff (!rst_n)
      $fell(input_strobe_n) |-> !input_strobe_n [*4] ##1 input_strobe_n;
   endproperty
   a_strobe_low: assert property (p_strobe_low)
      else $error("input strobe low width wrong");

   // Exactly one latch select is up when a command or address byte latches.
   property p_cmd_latch;
      @(posedge clock) disable iff (!rst_n)
      $rose(input_strobe_n) |-> command_latch_sel != address_latch_sel || kind == kind_data_in;
   endproperty
   a_cmd_latch: assert property (p_cmd_latch)
      else $error("latch selects wrong at strobe rise");

   // The read strobe is held low past the access delay before data is taken.
   property p_read_access;
      @(posedge clock) disable iff (!rst_n)
      $fell(output_strobe_n) |-> !output_strobe_n [*4];
   endproperty
   a_read_access: assert property (p_read_access)
      else $error("output strobe too short");

   // Read and write strobes never overlap.
   property p_no_overlap;
      @(posedge clock) disable iff (!rst_n)
      !(!input_strobe_n && !output_strobe_n);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("both strobes low");

   // A control write that meets a running cycle must wait.
   property p_stall;
      @(posedge clock) disable iff (!rst_n)
      (wr_pend && wr_addr == reg_control && state != st_idle) |-> !hreadyout;
   endproperty
   a_stall: assert property (p_stall)
      else $error("control write not stalled");

   // The load tally never passes the partial program limit.
   property p_partial;
      @(posedge clock) disable iff (!rst_n)
      partial_count <= partial_limit;
   endproperty
   a_partial: assert property (p_partial)
      else $error("partial count over limit");

   // The host releases the byte bus while the flash drives it.
   property p_bus_drive;
      @(posedge clock) disable iff (!rst_n)
      !output_strobe_n |-> !data_bus_oe;
   endproperty
   a_bus_drive: assert property (p_bus_drive)
      else $error("bus driven during read");

   // Every pin cycle has four low and then high clock cycles.
   property p_cycle_len;
      @(posedge clock) disable iff (!rst_n)
      (state == st_idle && next_state == st_low) |=> state == st_low [*4] ##1 state == st_high;
   endproperty
   a_cycle_len: assert property (p_cycle_len)
      else $error("cycle length wrong");

   // A refused fifth load strobes nothing; the sequencer stays idle.
   property p_refuse_idle;
      @(posedge clock) disable iff (!rst_n)
      (start && refused_now()) |=> state == st_idle;
   endproperty
   a_refuse_idle: assert property (p_refuse_idle)
      else $error("refused load still strobed");

   // Protect level only moves between cycles, never inside one.
   property p_protect_hold;
      @(posedge clock) disable iff (!rst_n)
      (state != st_idle && $past(state) != st_idle) |-> $stable(protect_n);
   endproperty
   a_protect_hold: assert property (p_protect_hold)
      else $error("protect level moved inside a cycle");

   // Sending the end command leaves the cache read.
   property p_cache_exit;
      @(posedge clock) disable iff (!rst_n)
      (cmd_taken && hwdata[7:0] == cmd_cache_read_end) |=> !in_cache_read;
   endproperty
   a_cache_exit: assert property (p_cache_exit)
      else $error("cache read not left");

   // The tracker follows the byte put on the pins.
   property p_last_cmd;
      @(posedge clock) disable iff (!rst_n)
      cmd_taken |=> last_cmd == out_byte;
   endproperty
   a_last_cmd: assert property (p_last_cmd)
      else $error("command tracker out of step");

   // =========================================================
   // Coverage of the main scenarios
   c_cmd: cover property (@(posedge clock) $rose(input_strobe_n) && command_latch_sel);
   c_addr: cover property (@(posedge clock) $rose(input_strobe_n) && address_latch_sel);
   c_read: cover property (@(posedge clock) $rose(output_strobe_n));
   c_refuse: cover property (@(posedge clock) refused);
   c_cache: cover property (@(posedge clock) in_cache_read);
endmodule
`default_nettype wire

// ---- tb/flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// =========================================================
// Behavioural flash device driven through its pins.
module flash_model
#(
   parameter logic [7:0] maker_code = 8'h5a // Arbitrary value.
)
(
   // Flash pins
   input wire logic chip_select_n,
   input wire logic command_latch_sel,
   input wire logic address_latch_sel,
   input wire logic input_strobe_n,
   input wire logic output_strobe_n,
   input wire logic protect_n,
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic busy_pull
);
   logic [7:0] status_register = 8'he0;
   logic [7:0] mode = 8'h00; // Power-up sits in read mode.
   logic [7:0] column = 8'h00;
   logic [7:0] shown = 8'h00;
   logic first = 1'b0;
   logic live = 1'b0;
   int span = 0;
   event go;
   // Busy intervals hold the open-drain line low.
   initial busy_pull = 1'b0;
   always @(go)
   begin
      busy_pull = 1'b1;
      #(span);
      busy_pull = 1'b0;
   end
   // Bytes latch on the rising input strobe only while selected.
   always @(posedge input_strobe_n)
   begin
      if (!chip_select_n && address_latch_sel && first)
      begin
         column = bus_in;
         first = 1'b0;
      end
      else if (!chip_select_n && command_latch_sel
         && (!busy_pull || bus_in == 8'h70 || bus_in == 8'hff))
      begin
         mode = bus_in;
         first = 1'b1;
         span = (bus_in == 8'h30) ? 500 : (bus_in == 8'h10) ? 1000 : 50;
         if (bus_in == 8'h30 || (bus_in == 8'h10 && protect_n) || bus_in == 8'hff)
            -> go;
         if (bus_in == 8'h10)
            status_register[0] = !protect_n;
         if (bus_in == 8'hff)
            status_register = 8'he0;
      end
   end
   // Falling output strobe yields the next byte after the access delay.
   always @(negedge output_strobe_n)
   begin
      shown = (mode == 8'h90) ? maker_code ^ column : column;
      if (mode == 8'h70)
         shown = {status_register[7], !busy_pull, !busy_pull, status_register[4:0]};
      column = column + 8'h01;
      #15 live = 1'b1;
   end
   // A released bus shows the inverse, so a stale byte cannot pass.
   always @(posedge output_strobe_n)
      #5 live = 1'b0;
   assign bus_out = live ? shown : ~shown;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define chk(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
$display("BAD %0t got %h exp %h", $time, g, e); end end
// =========================================================
// Self-checking bench for the flash host.
module tb;
   import nand_host_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, wp = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic cs_n, cle, ale, we_n, re_n, prot_n, oe, busy_pull;
   logic [7:0] dout, flash_out;
   int fail_count = 0, checks_done = 0;
   // Bus level from all drivers; ready line pulled up.
   wire logic [7:0] bus = oe ? dout : flash_out;
   wire logic rb_n = busy_pull ? 1'b0 : 1'b1;
   nand_host nand_host_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .chip_select_n(cs_n),
      .command_latch_sel(cle), .address_latch_sel(ale), .input_strobe_n(we_n),
      .output_strobe_n(re_n), .protect_n(prot_n), .data_bus_out(dout), .data_bus_oe(oe),
      .data_bus_in(bus), .ready_busy_n(rb_n));
   flash_model flash_model_inst (.chip_select_n(cs_n), .command_latch_sel(cle),
      .address_latch_sel(ale), .input_strobe_n(we_n), .output_strobe_n(re_n),
      .protect_n(prot_n), .bus_in(bus), .bus_out(flash_out), .busy_pull(busy_pull));
   // Clock source.
   initial
      forever #2.5 clock = ~clock;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One single AHB transfer; waits are cut only by the watchdog.
   task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic ctl(input logic [1:0] k, input logic [7:0] b);
      bus_xfer(1'b1, reg_control, {20'h0, wp, 1'b1, k, b});
      // Reads are not stalled, so wait until the pin cycle is over.
      do bus_xfer(1'b0, reg_status, 32'h0); while (q[st_busy_bit] !== 1'b0);
   endtask
   task automatic expect_byte(input logic [7:0] e);
      ctl(kind_data_out, 8'h00);
      bus_xfer(1'b0, reg_rdata, 32'h0);
      `chk(q, {24'h0, e})
   endtask
   task automatic wait_ready;
      repeat (400)
      begin
         bus_xfer(1'b0, reg_status, 32'h0);
         if (q[st_ready_bit] === 1'b1)
            break;
      end
      `chk(q[st_ready_bit], 1'b1)
   endtask
   // Page read: busy while loading, then sequential bytes from the column.
   task automatic t_read;
      ctl(kind_command, cmd_read_setup);
      for (int i = 0; i < 4; i++) ctl(kind_address, (i == 0) ? 8'h10 : 8'h00);
      ctl(kind_command, cmd_read_confirm);
      bus_xfer(1'b0, reg_status, 32'h0);
      `chk(q[st_ready_bit], 1'b0)
      wait_ready();
      expect_byte(8'h10);
      expect_byte(8'h11);
   endtask
   // Load, confirm, then status pass or fail.
   task automatic t_program(input logic [7:0] e);
      ctl(kind_command, cmd_program_load);
      repeat (4) ctl(kind_address, 8'h00);
      ctl(kind_data_in, 8'h3c);
      ctl(kind_command, cmd_program_confirm);
      wait_ready();
      ctl(kind_command, cmd_read_status);
      expect_byte(e);
   endtask
   // Main sequence.
   initial
   begin
      repeat (8) @(posedge clock);
      `chk({cs_n, prot_n, oe}, 3'h4)
      rst_n <= 1'b1;
      @(posedge clock);
      bus_xfer(1'b0, reg_status, 32'h0);
      `chk(q, 32'h2)
      bus_xfer(1'b0, 8'h20, 32'h0);
      `chk(q, 32'h0)
      t_read();
      ctl(kind_command, cmd_read_id);
      ctl(kind_address, id_address);
      for (int i = 0; i < 4; i++) expect_byte(8'h5a ^ 8'(i));
      repeat (4) t_program(8'he0);
      ctl(kind_command, cmd_program_load);
      bus_xfer(1'b0, reg_status, 32'h0);
      `chk(q[st_refused_bit], 1'b1)
      bus_xfer(1'b0, reg_partial, 32'h0);
      `chk(q, 32'h4)
      ctl(kind_command, cmd_reset);
      wait_ready();
      bus_xfer(1'b0, reg_partial, 32'h0);
      `chk(q, 32'h0)
      wp = 1'b0;
      t_program(8'he1);
      `chk(hresp, 1'b0)
      give_verdict();
   end
   // Watchdog well past the expected run.
   initial
   begin
      #300us;
      fail_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
